/* File: design/usc_pkg.sv */
// Package: constants and carriers for the setup/error/lock command block
package usc_pkg;
  localparam logic [7:0] CMD_ACK_SETUP = 8'hF4;
  localparam logic [7:0] CMD_ERR_FIRST = 8'hA0;
  localparam logic [7:0] CMD_ERR_LAST = 8'hAF;
  localparam logic [7:0] CMD_UNLOCK = 8'hB0;
  localparam logic [7:0] CMD_SCR_WR = 8'hB2;
  localparam logic [7:0] CMD_SCR_RD = 8'hB3;
  localparam logic [15:0] UNLOCK_KEY = 16'hAA37;
  localparam logic [15:0] SCRATCH_MASK = 16'h1FFF;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam int ST_OVERRUN = 7;
  localparam int ST_TOGGLE = 6;
  localparam int ST_ERR_LO = 1;
  localparam int ST_OK = 0;
  localparam int NUM_EP = 16;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_PID_ENC = 4'h1;
  localparam logic [3:0] ERR_PID_UNK = 4'h2;
  localparam logic [3:0] ERR_UNEXP = 4'h3;
  localparam logic [3:0] ERR_TOK_CRC = 4'h4;
  localparam logic [3:0] ERR_DAT_CRC = 4'h5;
  localparam logic [3:0] ERR_TIMEOUT = 4'h6;
  localparam logic [3:0] ERR_BABBLE = 4'h7;
  localparam logic [3:0] ERR_EOP = 4'h8;
  localparam logic [3:0] ERR_NAK = 4'h9;
  localparam logic [3:0] ERR_STALL = 4'hA;
  localparam logic [3:0] ERR_OVFL = 4'hB;
  localparam logic [3:0] ERR_ISO_EMPTY = 4'hC;
  localparam logic [3:0] ERR_STUFF = 4'hD;
  localparam logic [3:0] ERR_SYNC = 4'hE;
  localparam logic [3:0] ERR_TOGGLE = 4'hF;

  typedef enum logic [1:0] {
    USC_IDLE = 2'b00,
    USC_WAIT_UNLOCK = 2'b01,
    USC_WAIT_SCR_WR = 2'b10,
    USC_WAIT_READ = 2'b11
  } usc_phase_t;

  // One transaction result from the engine
  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic ok;
    logic toggle;
    logic [3:0] err;
  } usc_txn_t;

  // Processor bus access, one cycle per phase
  typedef struct packed {
    logic cmd;
    logic wr;
    logic rd;
    logic [15:0] data;
  } usc_bus_t;
endpackage : usc_pkg

/* File: design/usc_cmd.sv */
// Setup acknowledge, endpoint error codes, unlock and scratch commands
// How it works
// - Setup arrival blocks validate/clear buffer for control endpoints.
// - Command F4, no data, re-enables those control buffer commands.
// - Codes A0..AF pick an endpoint; one status word is then read.
// - Each new transaction replaces that endpoint's stored status.
// - Bit 7 set when status updates before previous one was read.
// - Bit 6 is data PID of last good packet, 1 for DATA1.
// - Bits 4..1 error code, bit 5 reserved; read-only, reset zero.
// - Bit 0 set when data moved successfully.
// - Codes 0000 none, 0001 PID check, 0010 unknown PID.
// - Code 0011 for wrong packet type or token to non-control.
// - CRC, timeout, babble, EOP, stuff, sync: 0100..1000,1101,1110.
// - Code 1001 for NAK sent or received.
// - Code 1010 when stall handshake answered a token.
// - Code 1011 when received packet overflowed buffer.
// - Code 1100 when isochronous endpoint sent empty packet.
// - Code 1111 for wrong toggle; packet data discarded.
// - In suspend, processor writes to registers and FIFOs are refused.
// - After resume, reads are refused too until unlock is done.
// - Command B0 then word AA37 lifts protection; other values do not.
// - Scratch written with B2, read with B3, one 16-bit word.
// - Scratch bits 12..0 store data, reset zero; 15..13 kept zero.
module usc_cmd (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire usc_pkg::usc_bus_t bus_i,
  input wire usc_pkg::usc_txn_t txn_i,
  input wire logic setup_arrived_i,
  input wire logic suspend_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic ctrl_buf_cmd_en_o,
  output logic write_locked_o,
  output logic read_locked_o,
  output logic write_allowed_o,
  output logic discard_data_o
);

  //////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    usc_pkg::usc_phase_t phase;
    logic [3:0] sel_ep;
    logic [usc_pkg::NUM_EP-1:0][7:0] status;
    logic [usc_pkg::NUM_EP-1:0] status_overrun;
    logic [15:0] scratch;
    logic ctrl_en;
    logic wlock;
    logic rlock;
    logic [1:0] susp_sync;
    logic [15:0] rd_data;
    logic rd_valid;
    logic discard;
    logic rd_scr;
    logic wallow;
  } usc_state_t;

  usc_state_t st_q;
  usc_state_t st_d;
  logic susp_now;
  logic [7:0] new_status;
  logic [3:0] new_ep;
  logic new_valid;

  default clocking cb_main @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  assign susp_now = st_q.susp_sync[1];

  // Status byte for a fresh transaction
  function automatic logic [7:0] usc_pack_status(input logic overrun,
      input logic tog, input logic [3:0] err, input logic ok);
    logic [7:0] s;
    s = usc_pkg::STATUS_RESET;
    s[usc_pkg::ST_OVERRUN] = overrun;
    s[usc_pkg::ST_TOGGLE] = tog;
    s[usc_pkg::ST_ERR_LO +: 4] = err;
    s[usc_pkg::ST_OK] = ok;
    return s;
  endfunction : usc_pack_status

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d = st_q;
    st_d.rd_valid = 1'b0;
    st_d.discard = 1'b0;
    // Only the second stage feeds logic
    st_d.susp_sync = {st_q.susp_sync[0], suspend_i};
    new_valid = txn_i.valid;
    new_ep = txn_i.ep;
    new_status = usc_pkg::STATUS_RESET;

    // Suspend locks writes and reads at once; both stay locked until unlock
    if (susp_now) begin
      st_d.wlock = 1'b1;
      st_d.rlock = 1'b1;
    end

    // Transaction status capture
    if (new_valid) begin
      // Toggle bit only follows a good packet; else keep the last one
      new_status = usc_pack_status(
          st_q.status_overrun[new_ep],
          txn_i.ok ? txn_i.toggle
                   : st_q.status[new_ep][usc_pkg::ST_TOGGLE],
          txn_i.err,
          txn_i.ok);
      st_d.status[new_ep] = new_status;
      st_d.status_overrun[new_ep] = 1'b1;
      // Wrong toggle data is dropped by the buffer logic
      st_d.discard = (txn_i.err == usc_pkg::ERR_TOGGLE);
    end

    // Setup arrival wins over an ack in the same cycle
    if (bus_i.cmd && bus_i.data[7:0] == usc_pkg::CMD_ACK_SETUP) begin
      st_d.ctrl_en = 1'b1;
    end
    if (setup_arrived_i) begin
      st_d.ctrl_en = 1'b0;
    end

    // Command phase decodes first, data phase follows
    if (bus_i.cmd) begin
      st_d.phase = usc_pkg::USC_IDLE;
      if (bus_i.data[7:0] >= usc_pkg::CMD_ERR_FIRST &&
          bus_i.data[7:0] <= usc_pkg::CMD_ERR_LAST) begin
        st_d.phase = usc_pkg::USC_WAIT_READ;
        st_d.sel_ep = bus_i.data[3:0];
        st_d.rd_scr = 1'b0;
        // A locked read must not leak the snapshot on the data lines
        st_d.rd_data = st_q.rlock ? 16'h0000 :
            {8'h00, st_q.status[bus_i.data[3:0]]};
      end else if (bus_i.data[7:0] == usc_pkg::CMD_SCR_RD) begin
        st_d.phase = usc_pkg::USC_WAIT_READ;
        st_d.sel_ep = 4'hF;
        st_d.rd_scr = 1'b1;
        st_d.rd_data = st_q.rlock ? 16'h0000 : st_q.scratch;
      end else if (bus_i.data[7:0] == usc_pkg::CMD_UNLOCK) begin
        st_d.phase = usc_pkg::USC_WAIT_UNLOCK;
      end else if (bus_i.data[7:0] == usc_pkg::CMD_SCR_WR) begin
        st_d.phase = usc_pkg::USC_WAIT_SCR_WR;
      end
    end else begin
      unique case (st_q.phase)
        usc_pkg::USC_IDLE: begin
        end
        usc_pkg::USC_WAIT_UNLOCK: begin
          if (bus_i.wr) begin
            st_d.phase = usc_pkg::USC_IDLE;
            // Unlock only once the bus is awake again
            if (bus_i.data == usc_pkg::UNLOCK_KEY && !susp_now) begin
              st_d.wlock = 1'b0;
              st_d.rlock = 1'b0;
            end
          end
        end
        usc_pkg::USC_WAIT_SCR_WR: begin
          if (bus_i.wr) begin
            st_d.phase = usc_pkg::USC_IDLE;
            // Reserved bits are forced low regardless of what is written
            if (!st_q.wlock) begin
              st_d.scratch = bus_i.data & usc_pkg::SCRATCH_MASK;
            end
          end
        end
        usc_pkg::USC_WAIT_READ: begin
          if (bus_i.rd) begin
            st_d.phase = usc_pkg::USC_IDLE;
            // Locked reads return zero and leave the status_overrun flag alone
            if (!st_q.rlock) begin
              st_d.rd_valid = 1'b1;
              if (!st_q.rd_scr) begin
                st_d.status_overrun[st_q.sel_ep] = new_valid && new_ep == st_q.sel_ep;
              end
            end else begin
              st_d.rd_data = 16'h0000;
            end
          end
        end
      endcase
    end
    // Own flop so the output needs no gate after the register
    st_d.wallow = ~st_d.wlock;
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
      st_q.ctrl_en <= 1'b1;
      st_q.wallow <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data_o = st_q.rd_data;
  assign rd_valid_o = st_q.rd_valid;
  assign ctrl_buf_cmd_en_o = st_q.ctrl_en;
  assign write_locked_o = st_q.wlock;
  assign read_locked_o = st_q.rlock;
  assign write_allowed_o = st_q.wallow;
  assign discard_data_o = st_q.discard;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  // Antecedents built from the bus phases and the setup and transaction inputs the decoder reacts to
  sequence s_setup;
    setup_arrived_i;
  endsequence

  sequence s_ack;
    bus_i.cmd && bus_i.data[7:0] == usc_pkg::CMD_ACK_SETUP &&
        !setup_arrived_i;
  endsequence

  sequence s_status_cmd;
    bus_i.cmd && bus_i.data[7:0] >= usc_pkg::CMD_ERR_FIRST &&
        bus_i.data[7:0] <= usc_pkg::CMD_ERR_LAST;
  endsequence

  sequence s_scr_cmd;
    bus_i.cmd && bus_i.data[7:0] == usc_pkg::CMD_SCR_RD;
  endsequence

  sequence s_key_word;
    st_q.phase == usc_pkg::USC_WAIT_UNLOCK && bus_i.wr && !bus_i.cmd;
  endsequence

  sequence s_scr_word;
    st_q.phase == usc_pkg::USC_WAIT_SCR_WR && bus_i.wr && !bus_i.cmd;
  endsequence

  sequence s_rd_word;
    st_q.phase == usc_pkg::USC_WAIT_READ && bus_i.rd && !bus_i.cmd;
  endsequence

  sequence s_txn;
    txn_i.valid;
  endsequence

  setup_blocks_a: assert property (
      s_setup |=> !ctrl_buf_cmd_en_o)
    else $error("setup did not block control buffer commands");

  ack_enables_a: assert property (
      s_ack |=> ctrl_buf_cmd_en_o)
    else $error("acknowledge did not re-enable commands");

  status_store_a: assert property (
      s_txn |=> st_q.status[$past(txn_i.ep)][4:0] ==
          {$past(txn_i.err), $past(txn_i.ok)})
    else $error("transaction status not stored");

  overrun_set_a: assert property (
      s_txn ##0 st_q.status_overrun[txn_i.ep] |=>
          st_q.status[$past(txn_i.ep)][usc_pkg::ST_OVERRUN])
    else $error("overrun bit not set");

  status_overrun_mark_a: assert property (
      s_txn |=> st_q.status_overrun[$past(txn_i.ep)])
    else $error("new status not marked status_overrun");

  toggle_take_a: assert property (
      s_txn ##0 txn_i.ok |=> st_q.status[$past(txn_i.ep)][usc_pkg::ST_TOGGLE]
          == $past(txn_i.toggle))
    else $error("toggle of good packet not stored");

  toggle_keep_a: assert property (
      s_txn ##0 !txn_i.ok |=>
          st_q.status[$past(txn_i.ep)][usc_pkg::ST_TOGGLE] ==
          $past(st_q.status[txn_i.ep][usc_pkg::ST_TOGGLE]))
    else $error("failed packet changed toggle bit");

  ok_bit_a: assert property (
      s_txn |=> st_q.status[$past(txn_i.ep)][usc_pkg::ST_OK] ==
          $past(txn_i.ok))
    else $error("success bit not stored");

  reserved_zero_a: assert property (
      rd_valid_o && !st_q.rd_scr |->
          rd_data_o[15:8] == 8'h00 && rd_data_o[5] == 1'b0)
    else $error("status read upper bits not zero");

  status_read_a: assert property (
      s_status_cmd ##0 !read_locked_o |=>
          rd_data_o == {8'h00, $past(st_q.status[bus_i.data[3:0]])})
    else $error("status snapshot wrong");

  scratch_read_a: assert property (
      s_scr_cmd ##0 !read_locked_o |=> rd_data_o == $past(st_q.scratch))
    else $error("scratch snapshot wrong");

  read_answer_a: assert property (
      s_rd_word ##0 !read_locked_o |=> rd_valid_o)
    else $error("read word not answered");

  suspend_lock_a: assert property (
      suspend_i ##2 1'b1 |=> write_locked_o && read_locked_o)
    else $error("suspend did not lock writes");

  allow_mirror_a: assert property (
      write_allowed_o == !write_locked_o)
    else $error("write allowed disagrees with lock");

  locked_read_a: assert property (
      read_locked_o |=> !rd_valid_o)
    else $error("read answered while locked");

  locked_zero_a: assert property (
      s_rd_word ##0 read_locked_o |=> rd_data_o == 16'h0000)
    else $error("locked read showed data");

  unlock_key_a: assert property (
      s_key_word ##0 bus_i.data != usc_pkg::UNLOCK_KEY && write_locked_o
          |=> write_locked_o)
    else $error("wrong key lifted protection");

  unlock_open_a: assert property (
      s_key_word ##0 bus_i.data == usc_pkg::UNLOCK_KEY && !susp_now
          |=> !write_locked_o && !read_locked_o)
    else $error("right key did not lift protection");

  scratch_write_a: assert property (
      s_scr_word ##0 !write_locked_o |=>
          st_q.scratch == ($past(bus_i.data) & usc_pkg::SCRATCH_MASK))
    else $error("scratch write not stored");

  locked_write_a: assert property (
      s_scr_word ##0 write_locked_o |=> $stable(st_q.scratch))
    else $error("scratch written while locked");

  scratch_mask_a: assert property (
      st_q.scratch[15:13] == 3'b000)
    else $error("scratch reserved bits set");

  toggle_drop_a: assert property (
      s_txn ##0 txn_i.err == usc_pkg::ERR_TOGGLE |=> discard_data_o)
    else $error("wrong toggle data not discarded");

  discard_quiet_a: assert property (
      !(txn_i.valid && txn_i.err == usc_pkg::ERR_TOGGLE) |=> !discard_data_o)
    else $error("data discarded without toggle error");

endmodule : usc_cmd

/* File: tb/usc_proc_model.sv */
// Processor-side model that drives the command and data bus
module usc_proc_model (
  input wire logic clk_i,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_valid_i,
  output usc_pkg::usc_bus_t bus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bus_o = '0;
  task automatic phase(input logic c, w, r, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    bus_o = '{cmd: c, wr: w, rd: r, data: d};
  endtask : phase
  // Code on the low byte first, then at most one word, then release
  task automatic access(input logic [7:0] code, input logic w, r,
      input logic [15:0] d, output logic [15:0] got, output logic seen);
    phase(1'b1, 1'b0, 1'b0, {8'h00, code});
    if (w || r) begin
      phase(1'b0, w, r, d);
    end
    // Released lines show junk, not the last word
    phase(1'b0, 1'b0, 1'b0, ~bus_o.data);
    seen = 1'b0;
    got = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      if (rd_valid_i === 1'b1) begin
        seen = 1'b1;
        got = rd_data_i;
        break;
      end
      @(posedge clk_i);
      #1;
    end
  endtask : access
endmodule : usc_proc_model

/* File: tb/usb_device_setup_error_lock_cmds_bench.sv */
// Self-checking bench for the setup, error code, lock and scratch block
module usb_device_setup_error_lock_cmds_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic setup_i = 1'b0;
  logic susp_i = 1'b0;
  usc_pkg::usc_bus_t bus;
  usc_pkg::usc_txn_t txn = '0;
  logic [15:0] rdat;
  logic rval, en, wl, rl, wa, disc, s;
  logic [15:0] g;
  int bad_count = 0;
  int num_checks = 0;
  always #50 clk_i = ~clk_i;
  usc_proc_model i_proc (.clk_i(clk_i), .rd_data_i(rdat),
    .rd_valid_i(rval), .bus_o(bus));
  usc_cmd i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
    .txn_i(txn), .setup_arrived_i(setup_i), .suspend_i(susp_i),
    .rd_data_o(rdat), .rd_valid_o(rval), .ctrl_buf_cmd_en_o(en),
    .write_locked_o(wl), .read_locked_o(rl), .write_allowed_o(wa),
    .discard_data_o(disc));
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // A missing answer is a hang: stop the run there
  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
    i_proc.access(code, 1'b0, 1'b1, 16'h0000, g, s);
    chk("rd_valid_o", 16'h0001, {15'h0000, s});
    if (!s) begin
      give_verdict();
    end
    chk("rd_data_o", exp, g);
  endtask : rd_chk
  task automatic rd_err(input int e);
    rd_chk(usc_pkg::CMD_ERR_FIRST + 8'(e), {11'h000, 4'(e), 1'b0});
  endtask : rd_err
  task automatic pulse_txn(input logic [3:0] ep, input logic ok, tg,
      input logic [3:0] err);
    @(posedge clk_i);
    #1;
    txn = '{valid: 1'b1, ep: ep, ok: ok, toggle: tg, err: err};
    @(posedge clk_i);
    #1;
    txn.valid = 1'b0;
  endtask : pulse_txn
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("ctrl_buf_cmd_en_o", 16'h0001, {15'h0000, en});
    chk("write_allowed_o", 16'h0001, {15'h0000, wa});
    rd_chk(usc_pkg::CMD_ERR_FIRST, 16'h0000);
    rd_chk(usc_pkg::CMD_SCR_RD, 16'h0000);
  endtask : t_reset
  task automatic t_setup();
    @(posedge clk_i);
    #1;
    setup_i = 1'b1;
    @(posedge clk_i);
    #1;
    setup_i = 1'b0;
    chk("ctrl_buf_cmd_en_o", 16'h0000, {15'h0000, en});
    i_proc.access(usc_pkg::CMD_ACK_SETUP, 1'b0, 1'b0, 16'h0, g, s);
    chk("ctrl_buf_cmd_en_o", 16'h0001, {15'h0000, en});
  endtask : t_setup
  // Every error code once, each on its own endpoint
  task automatic t_codes();
    for (int e = 0; e < 16; e++) begin
      pulse_txn(4'(e), e == 0, 1'b1, 4'(e));
      chk("discard_data_o", {15'h0000, e == 15}, {15'h0000, disc});
    end
    rd_chk(usc_pkg::CMD_ERR_FIRST, 16'h0041);
    rd_err(1);
    rd_err(2);
    rd_err(3);
    for (int e = 4; e < 9; e++) begin
      rd_err(e);
    end
    rd_err(9);
    rd_err(10);
    rd_err(11);
    rd_err(12);
    rd_err(13);
    rd_err(14);
    rd_err(15);
  endtask : t_codes
  task automatic t_overrun();
    pulse_txn(4'h2, 1'b1, 1'b0, 4'h0);
    pulse_txn(4'h2, 1'b0, 1'b0, 4'h9);
    rd_chk(8'hA2, 16'h0092);
    // The read cleared the pending mark, so this event is no overrun
    pulse_txn(4'h2, 1'b1, 1'b1, 4'h0);
    rd_chk(8'hA2, 16'h0041);
  endtask : t_overrun
  task automatic t_lock();
    i_proc.access(usc_pkg::CMD_SCR_WR, 1'b1, 1'b0, 16'h1ABC, g, s);
    rd_chk(usc_pkg::CMD_SCR_RD, 16'h1ABC);
    susp_i = 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    chk("write_locked_o", 16'h0001, {15'h0000, wl});
    chk("write_allowed_o", 16'h0000, {15'h0000, wa});
    i_proc.access(usc_pkg::CMD_SCR_WR, 1'b1, 1'b0, 16'h0055, g, s);
    susp_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    chk("read_locked_o", 16'h0001, {15'h0000, rl});
    i_proc.access(usc_pkg::CMD_SCR_RD, 1'b0, 1'b1, 16'h0, g, s);
    chk("locked rd_valid_o", 16'h0000, {15'h0000, s});
    chk("locked rd_data_o", 16'h0000, rdat);
    i_proc.access(usc_pkg::CMD_UNLOCK, 1'b1, 1'b0, 16'hAA36, g, s);
    chk("write_locked_o", 16'h0001, {15'h0000, wl});
    i_proc.access(usc_pkg::CMD_UNLOCK, 1'b1, 1'b0, 16'hAA37, g, s);
    chk("write_locked_o", 16'h0000, {15'h0000, wl});
    chk("read_locked_o", 16'h0000, {15'h0000, rl});
    rd_chk(usc_pkg::CMD_SCR_RD, 16'h1ABC);
  endtask : t_lock
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_setup();
    t_codes();
    t_overrun();
    t_lock();
    give_verdict();
  end
endmodule : usb_device_setup_error_lock_cmds_bench
